//--- hw/lsgp_consts.svh
// register offsets, field positions and reset values of the shared gpio ports
`ifndef LSGP_CONSTS_SVH
`define LSGP_CONSTS_SVH
`define LSGP_OFF_C_DATA   8'h02
`define LSGP_OFF_D_DATA   8'h03
`define LSGP_OFF_E_DATA   8'h09
`define LSGP_OFF_C_DIR    8'h06
`define LSGP_OFF_D_DIR    8'h07
`define LSGP_OFF_E_DIR    8'h0D
`define LSGP_OFF_OPTION   8'h1E
`define LSGP_OFF_DISPLAY  8'h20
`define LSGP_BIT_D_LCD    1
`define LSGP_BIT_E_LCD    2
`define LSGP_BIT_LCD_ON   0
`define LSGP_DIR_RESET    8'h00
`define LSGP_OPT_RESET    8'h00
`define LSGP_DISP_RESET   8'h00
`define LSGP_SYNC_RESET   2'h0
`endif

//--- hw/lsgp_pkg.sv
// types shared by the shared gpio port files
`default_nettype none
package lsgp_pkg;
   typedef logic [7:0] lsgp_byte_type;
   typedef enum logic [1:0] {
      lsgp_sel_none,
      lsgp_sel_gpio,
      lsgp_sel_display
   } lsgp_owner_type;
endpackage
`default_nettype wire

//--- hw/lsgp_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
`include "lsgp_consts.svh"
module lsgp_sync (
   // clock and reset
   input  wire  logic mclk,
   input  wire  logic resetn,
   // level in and out
   input  wire  logic async_in,
   output var   logic sync_out
);
   logic [1:0] stage_reg;

   // first stage is read only by the second
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stage_reg <= `LSGP_SYNC_RESET;
      end else begin
         stage_reg <= {stage_reg[0], async_in};
      end
   end

   assign sync_out = stage_reg[1];
endmodule
`default_nettype wire

//--- hw/lsgp_pin.sv
// one port pin: direction, latch, input sense and display override
`timescale 1ns/1ps
`default_nettype none
`include "lsgp_consts.svh"
module lsgp_pin (
   // clock and reset
   input  wire  logic mclk,
   input  wire  logic resetn,
   // control from the registers, display level from the driver
   input  wire  logic dir_bit,
   input  wire  logic latch_bit,
   input  wire  logic display_sel,
   input  wire  logic display_in,
   // pad
   input  wire  logic pad_in,
   output var   logic pad_out,
   output var   logic pad_oe,
   // read value
   output var   logic read_bit
);
   logic pin_level;

   lsgp_sync u_sync (
      .mclk     (mclk),
      .resetn   (resetn),
      .async_in (pad_in),
      .sync_out (pin_level)
   );

   // display takes the pad over whatever the direction and latch say
   always_comb begin
      if (display_sel) begin
         pad_out = display_in;
         pad_oe  = 1'b1;
      end else begin
         pad_out = latch_bit;
         pad_oe  = dir_bit;
      end
   end

   // outputs read the latch, inputs read the synchronised pin
   assign read_bit = dir_bit ? latch_bit : pin_level;
endmodule
`default_nettype wire

//--- hw/lsgp_top.sv
// three 8-bit gpio ports, two of them shareable with the display driver
`timescale 1ns/1ps
`default_nettype none
`include "lsgp_consts.svh"
module lsgp_top (
   // clock and reset
   input  wire  logic       mclk,
   input  wire  logic       resetn,
   // register port
   input  wire  logic [7:0] reg_addr,
   input  wire  logic [7:0] reg_wdata,
   input  wire  logic       reg_write,
   input  wire  logic       reg_read,
   output var   logic [7:0] reg_rdata,
   // frontplane signals from the display driver
   input  wire  logic [7:0] frontplane_outputs_upper,
   input  wire  logic [7:0] frontplane_outputs_lower,
   // third port pads
   input  wire  logic [7:0] c_pad_in,
   output var   logic [7:0] c_pad_out,
   output var   logic [7:0] c_pad_oe,
   // fourth port pads
   input  wire  logic [7:0] d_pad_in,
   output var   logic [7:0] d_pad_out,
   output var   logic [7:0] d_pad_oe,
   // fifth port pads
   input  wire  logic [7:0] e_pad_in,
   output var   logic [7:0] e_pad_out,
   output var   logic [7:0] e_pad_oe,
   // display ownership seen from outside
   output var   logic       fourth_port_lcd_active,
   output var   logic       fifth_port_lcd_active
);
   // stored state
   lsgp_pkg::lsgp_byte_type third_port_latch;
   lsgp_pkg::lsgp_byte_type fourth_port_latch;
   lsgp_pkg::lsgp_byte_type fifth_port_latch;
   lsgp_pkg::lsgp_byte_type third_port_direction;
   lsgp_pkg::lsgp_byte_type fourth_port_direction;
   lsgp_pkg::lsgp_byte_type fifth_port_direction;
   lsgp_pkg::lsgp_byte_type second_option_register;
   lsgp_pkg::lsgp_byte_type display_control_register;
   lsgp_pkg::lsgp_byte_type rdata_reg;
   lsgp_pkg::lsgp_byte_type rdata_next;
   // per pin read values
   lsgp_pkg::lsgp_byte_type c_read;
   lsgp_pkg::lsgp_byte_type d_read;
   lsgp_pkg::lsgp_byte_type e_read;
   lsgp_pkg::lsgp_owner_type d_owner;
   lsgp_pkg::lsgp_owner_type e_owner;
   logic fourth_port_lcd_enable;
   logic fifth_port_lcd_enable;
   logic display_driver_enable;

   // address decode used for both writes and reads
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // latches have no reset on purpose: contents survive a system reset
   always_ff @(posedge mclk) begin
      if (reg_write && hit(reg_addr, `LSGP_OFF_C_DATA)) begin
         third_port_latch <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, `LSGP_OFF_D_DATA)) begin
         fourth_port_latch <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, `LSGP_OFF_E_DATA)) begin
         fifth_port_latch <= reg_wdata;
      end
   end

   // direction registers come out of reset as all inputs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         third_port_direction  <= `LSGP_DIR_RESET;
         fourth_port_direction <= `LSGP_DIR_RESET;
         fifth_port_direction  <= `LSGP_DIR_RESET;
      end else if (reg_write) begin
         if (hit(reg_addr, `LSGP_OFF_C_DIR)) begin
            third_port_direction <= reg_wdata;
         end
         if (hit(reg_addr, `LSGP_OFF_D_DIR)) begin
            fourth_port_direction <= reg_wdata;
         end
         if (hit(reg_addr, `LSGP_OFF_E_DIR)) begin
            fifth_port_direction <= reg_wdata;
         end
      end
   end

   // display enables, cleared at reset so the pins start as gpio
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         second_option_register   <= `LSGP_OPT_RESET;
         display_control_register <= `LSGP_DISP_RESET;
      end else if (reg_write) begin
         if (hit(reg_addr, `LSGP_OFF_OPTION)) begin
            second_option_register <= reg_wdata;
         end
         if (hit(reg_addr, `LSGP_OFF_DISPLAY)) begin
            display_control_register <= reg_wdata;
         end
      end
   end

   assign fourth_port_lcd_enable = second_option_register[`LSGP_BIT_D_LCD];
   assign fifth_port_lcd_enable  = second_option_register[`LSGP_BIT_E_LCD];
   assign display_driver_enable  = display_control_register[`LSGP_BIT_LCD_ON];

   // whole-port ownership; both enables are needed to hand a port over
   always_comb begin
      d_owner = (fourth_port_lcd_enable && display_driver_enable) ?
                lsgp_pkg::lsgp_sel_display : lsgp_pkg::lsgp_sel_gpio;
      e_owner = (fifth_port_lcd_enable && display_driver_enable) ?
                lsgp_pkg::lsgp_sel_display : lsgp_pkg::lsgp_sel_gpio;
   end

   assign fourth_port_lcd_active = (d_owner == lsgp_pkg::lsgp_sel_display);
   assign fifth_port_lcd_active  = (e_owner == lsgp_pkg::lsgp_sel_display);

   // eight pins per port, bit n of latch and direction drive pin n
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pins
         lsgp_pin u_c (
            .mclk        (mclk),
            .resetn      (resetn),
            .dir_bit     (third_port_direction[gi]),
            .latch_bit   (third_port_latch[gi]),
            .display_sel (1'b0),
            .display_in  (1'b0),
            .pad_in      (c_pad_in[gi]),
            .pad_out     (c_pad_out[gi]),
            .pad_oe      (c_pad_oe[gi]),
            .read_bit    (c_read[gi])
         );
         lsgp_pin u_d (
            .mclk        (mclk),
            .resetn      (resetn),
            .dir_bit     (fourth_port_direction[gi]),
            .latch_bit   (fourth_port_latch[gi]),
            .display_sel (fourth_port_lcd_active),
            .display_in  (frontplane_outputs_upper[gi]),
            .pad_in      (d_pad_in[gi]),
            .pad_out     (d_pad_out[gi]),
            .pad_oe      (d_pad_oe[gi]),
            .read_bit    (d_read[gi])
         );
         lsgp_pin u_e (
            .mclk        (mclk),
            .resetn      (resetn),
            .dir_bit     (fifth_port_direction[gi]),
            .latch_bit   (fifth_port_latch[gi]),
            .display_sel (fifth_port_lcd_active),
            .display_in  (frontplane_outputs_lower[gi]),
            .pad_in      (e_pad_in[gi]),
            .pad_out     (e_pad_out[gi]),
            .pad_oe      (e_pad_oe[gi]),
            .read_bit    (e_read[gi])
         );
      end
   endgenerate

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = 8'h00;
      if (hit(reg_addr, `LSGP_OFF_C_DATA)) begin
         rdata_next = c_read;
      end else if (hit(reg_addr, `LSGP_OFF_D_DATA)) begin
         rdata_next = d_read;
      end else if (hit(reg_addr, `LSGP_OFF_E_DATA)) begin
         rdata_next = e_read;
      end else if (hit(reg_addr, `LSGP_OFF_C_DIR)) begin
         rdata_next = third_port_direction;
      end else if (hit(reg_addr, `LSGP_OFF_D_DIR)) begin
         rdata_next = fourth_port_direction;
      end else if (hit(reg_addr, `LSGP_OFF_E_DIR)) begin
         rdata_next = fifth_port_direction;
      end else if (hit(reg_addr, `LSGP_OFF_OPTION)) begin
         rdata_next = second_option_register;
      end else if (hit(reg_addr, `LSGP_OFF_DISPLAY)) begin
         rdata_next = display_control_register;
      end
   end

   // read data stands for one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (reg_read) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

//--- verif/lsgp_checker.sv
// concurrent checks on the ports of the shared gpio ports
`timescale 1ns/1ps
`default_nettype none
`include "lsgp_consts.svh"
module lsgp_checker (
   // clock and reset
   input wire logic       mclk,
   input wire logic       resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   // display signals and pads
   input wire logic [7:0] frontplane_outputs_upper,
   input wire logic [7:0] frontplane_outputs_lower,
   input wire logic [7:0] c_pad_out,
   input wire logic [7:0] c_pad_oe,
   input wire logic [7:0] d_pad_out,
   input wire logic [7:0] d_pad_oe,
   input wire logic [7:0] e_pad_in,
   input wire logic [7:0] e_pad_out,
   input wire logic [7:0] e_pad_oe,
   input wire logic       fourth_port_lcd_active,
   input wire logic       fifth_port_lcd_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // reset must float every pad, so this one is not disabled by reset
   a_reset_dir_clear: assert property (disable iff (1'b0)
      !resetn |-> (c_pad_oe | d_pad_oe | e_pad_oe) == 8'h00) else $error("pad driven in reset");
   a_dir_drives_oe: assert property (reg_write && reg_addr == `LSGP_OFF_C_DIR
      |=> c_pad_oe == $past(reg_wdata)) else $error("enable differs from direction");
   a_latch_drives_out: assert property (reg_write && reg_addr == `LSGP_OFF_C_DATA
      |=> c_pad_out == $past(reg_wdata)) else $error("latch not loaded");
   a_dir_reads_back: assert property (reg_read && reg_addr == `LSGP_OFF_C_DIR
      |=> reg_rdata == $past(c_pad_oe)) else $error("direction read wrong");
   a_read_gives_latch: assert property (reg_read && reg_addr == `LSGP_OFF_C_DATA
      && c_pad_oe == 8'hFF |=> reg_rdata == $past(c_pad_out)) else $error("latch read wrong");
   // synchronised input: level must be steady over the sync depth
   a_e_pin_read: assert property ($stable(e_pad_in)[*3] ##0 (reg_read
      && reg_addr == `LSGP_OFF_E_DATA && e_pad_oe == 8'h00) |=> reg_rdata == $past(e_pad_in))
      else $error("pin read wrong");
   a_d_gpio_oe: assert property ((reg_write && reg_addr == `LSGP_OFF_D_DIR)
      ##1 !fourth_port_lcd_active |-> d_pad_oe == $past(reg_wdata)) else $error("port d enable");
   a_d_lcd_owns: assert property (fourth_port_lcd_active |-> d_pad_oe == 8'hFF
      && d_pad_out == frontplane_outputs_upper) else $error("port d not on display");
   a_e_lcd_owns: assert property (fifth_port_lcd_active |-> e_pad_oe == 8'hFF
      && e_pad_out == frontplane_outputs_lower) else $error("port e not on display");
   // main scenarios reached
   cover property (fourth_port_lcd_active);
   cover property (fifth_port_lcd_active);
   cover property (reg_read && reg_addr == `LSGP_OFF_E_DATA && e_pad_oe == 8'h00);
endmodule
bind lsgp_top lsgp_checker u_chk (.*);
`default_nettype wire

//--- verif/lsgp_pad_model.sv
// outside world of one port: resolves each pad wire
`timescale 1ns/1ps
`default_nettype none
module lsgp_pad_model (
   // pads from the port
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   // level an outside source puts on floating pads
   input  wire logic [7:0] ext_level,
   // resolved wire back to the port
   output var  logic [7:0] pad_in
);
   // a driven pad shows the port's value, a floating one the outside source
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
      end
   end
endmodule
`default_nettype wire

//--- verif/lsgp_top_tb.sv
// self-checking bench for the shared gpio ports
`timescale 1ns/1ps
`default_nettype none
`include "lsgp_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module lsgp_top_tb;
   logic       mclk = 1'b0;
   logic       resetn = 1'b1; // starts high so the first reset is a real falling edge
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] fp_up = 8'h00;
   logic [7:0] fp_lo = 8'h00;
   logic [7:0] rdata, c_in, d_in, e_in, c_out, d_out, e_out, c_oe, d_oe, e_oe;
   logic       d_act, e_act;
   logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] dir_off [3] = '{`LSGP_OFF_C_DIR, `LSGP_OFF_D_DIR, `LSGP_OFF_E_DIR};
   logic [7:0] dat_off [3] = '{`LSGP_OFF_C_DATA, `LSGP_OFF_D_DATA, `LSGP_OFF_E_DATA};
   int         err_count = 0;
   int         compares = 0;
   lsgp_pad_model pc (.pad_out(c_out), .pad_oe(c_oe), .ext_level(ext[0]), .pad_in(c_in));
   lsgp_pad_model pd (.pad_out(d_out), .pad_oe(d_oe), .ext_level(ext[1]), .pad_in(d_in));
   lsgp_pad_model pe (.pad_out(e_out), .pad_oe(e_oe), .ext_level(ext[2]), .pad_in(e_in));
   lsgp_top uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
      .frontplane_outputs_upper(fp_up), .frontplane_outputs_lower(fp_lo),
      .c_pad_in(c_in), .c_pad_out(c_out), .c_pad_oe(c_oe),
      .d_pad_in(d_in), .d_pad_out(d_out), .d_pad_oe(d_oe),
      .e_pad_in(e_in), .e_pad_out(e_out), .e_pad_oe(e_oe),
      .fourth_port_lcd_active(d_act), .fifth_port_lcd_active(e_act));
   // 20 MHz clock
   always #25 mclk = ~mclk;
   task automatic do_reset;
      resetn <= 1'b0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
   endtask
   // one-cycle write; the extra 1 ns lets pad outputs settle before checks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   task automatic report_and_stop;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // cuts a hang short, far beyond the 120 or so cycles needed
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
   initial begin
      do_reset;
      for (int p = 0; p < 3; p++) begin
         rd(dir_off[p], 8'h00);
      end
      `CHK({c_oe, d_oe, e_oe}, 24'h000000)
      wr(`LSGP_OFF_C_DATA, 8'hA5);
      wr(`LSGP_OFF_C_DIR, 8'hFF);
      `CHK(c_out, 8'hA5)
      `CHK(c_oe, 8'hFF)
      // a second reset floats the pads but keeps the latch
      do_reset;
      `CHK(c_oe, 8'h00)
      wr(`LSGP_OFF_C_DIR, 8'hFF);
      rd(`LSGP_OFF_C_DATA, 8'hA5);
      // input bits read the pad, output bits the latch
      for (int p = 0; p < 3; p++) begin
         @(posedge mclk) ext[p] <= 8'h3C;
         wr(dir_off[p], 8'h00);
         wr(dat_off[p], 8'h55);
         rd(dat_off[p], 8'h3C);
         wr(dir_off[p], 8'hF0);
         rd(dat_off[p], 8'h5C);
         rd(dir_off[p], 8'hF0);
      end
      // every combination of the two port enables and the global enable
      @(posedge mclk) fp_up <= 8'h5A;
      fp_lo <= 8'hC3;
      wr(`LSGP_OFF_D_DIR, 8'h00);
      wr(`LSGP_OFF_E_DIR, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(`LSGP_OFF_OPTION, {5'h00, i[2:1], 1'b0});
         wr(`LSGP_OFF_DISPLAY, {7'h00, i[0]});
         `CHK(d_act, i[1] & i[0])
         `CHK(e_act, i[2] & i[0])
         `CHK(d_oe, (i[1] & i[0]) ? 8'hFF : 8'h00)
         `CHK(e_out, (i[2] & i[0]) ? 8'hC3 : 8'h55)
         `CHK(d_out, (i[1] & i[0]) ? 8'h5A : 8'h55)
         `CHK(e_oe, (i[2] & i[0]) ? 8'hFF : 8'h00)
      end
      wr(`LSGP_OFF_D_DIR, 8'h0F);
      `CHK({d_oe, d_out}, 16'hFF5A)
      // unmapped place: write ignored, read gives zero
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      rd(`LSGP_OFF_C_DIR, 8'hF0);
      report_and_stop;
   end
endmodule
`default_nettype wire
